// ==== rtl/pin_mux_pkg.sv ====
// Constants, field layout and peripheral function identifiers of the pin function multiplexer
package pin_mux_pkg;

	// ==========================================================
	// Register map: one 8-bit control register per pin, one address each
	localparam int ADDR_W = 5;
	localparam int NPIN = 24;
	localparam logic [4:0] REG_PORT8 = 5'h00; // Port 8 pins 0,1,2,3,6,7
	localparam logic [4:0] REG_PORT9 = 5'h06; // Port 9 pins 2,3
	localparam logic [4:0] REG_PORTA = 5'h08; // Port A pins 0..7
	localparam logic [4:0] REG_PORTB = 5'h10; // Port B pins 0..7
	localparam logic [4:0] REG_LAST = 5'h17; // Highest mapped address

	// ==========================================================
	// Control register fields
	localparam int SEL_LSB = 0;
	localparam int SEL_W = 6;
	localparam int IRQ_SEL_BIT = 6;
	localparam int ANALOG_SEL_BIT = 7;
	localparam logic [7:0] CTL_RST = 8'h00;
	localparam logic [5:0] SEL_MASK_FULL = 6'h3F; // Six-bit select field
	localparam logic [5:0] SEL_MASK_LEGACY = 6'h0F; // Four-bit select field
	localparam logic [5:0] SEL_HIZ = 6'h00;

	// ==========================================================
	// Pin index of the comparator analog input and reference (port A pins 3 and 4)
	localparam int PIN_CMP_IN = 11;
	localparam int PIN_CMP_REF = 12;

	// ==========================================================
	// External interrupt line fed by each pin; ports 8 and 9 feed none
	localparam logic [NPIN-1:0] IRQ_VALID = 24'hFFFF00;
	localparam logic [3:0] IRQ_LINE [NPIN] = '{
		4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0,
		4'h0, 4'hB, 4'hA, 4'h6, 4'h5, 4'h5, 4'hE, 4'h7,
		4'hC, 4'h4, 4'h2, 4'h3, 4'h4, 4'hD, 4'h6, 4'hF};

	// ==========================================================
	// Peripheral signals that can be attached to a pin
	typedef enum logic [6:0] {
		f_none,
		f_t0a, f_t0b, f_t0c, f_t0d, f_t1b, f_t2a, f_t3b, f_t3d, f_t4a, f_t4c, f_t4d,
		f_t5u, f_t5v, f_t5w, f_t6b, f_t6d, f_t7a, f_t7b, f_t7c,
		f_tclka, f_tclkb, f_tclkc, f_tclkd,
		f_t8rst0, f_t8rst1, f_t8clk0, f_t8clk3, f_t8out0,
		f_odis0, f_odis1, f_odis4, f_odis11, f_clk_acc_ref, f_adc_trig, f_adc_stat,
		f_spi_ss0, f_spi_ss1, f_spi_ss2, f_spi_ss3, f_spi_clk, f_spi_mo, f_spi_mi,
		f_sck10, f_rts10, f_cts10, f_rxd10, f_txd10,
		f_sck010, f_rts010, f_cts010, f_rxd010, f_txd010, f_drv_en010,
		f_rxd7, f_cts7, f_sck5, f_rxd5, f_txd5, f_cts5, f_sck12, f_rxd12, f_txd12, f_cts12,
		f_sck4, f_rxd4, f_txd4, f_cts4, f_sck6, f_rxd6, f_txd6, f_cts6,
		f_sck9, f_rxd9, f_txd9, f_cts9, f_sck11, f_rxd11, f_txd11, f_cts11,
		f_sck011, f_rxd011, f_txd011, f_cts011, f_drv_en011,
		f_rtim_in2, f_rtim_out2, f_rc_rx, f_cmp_out1,
		f_num
	} func_t;
	localparam int NFUNC = int'(f_num);

endpackage

// ==== rtl/pin_function_mux.sv ====
// Pin function multiplexer for ports 8, 9, A and B with its control registers
//
// Overview of operation
// - Six-bit select; zero leaves pin high-impedance
// - Legacy variant: four-bit select, zero is high-impedance
// - Port 8 pin 0 timer, channel 10/010 codes
// - Port 8 pins 1,2 timer and serial codes
// - Port 8 pin 3 timer, clock, flow codes
// - Port 8 pins 6,7 timer and serial codes
// - Port 9 pins 2,3 output-disable and serial
// - Port A pin 0 timer, reference, SPI select
// - Port A pin 1 eight-way function map
// - Port A pin 2 timer, serial, SPI select
// - Port A pin 3 timer, clock, serial
// - Port A pin 4 nine-way function map
// - Port A pin 5 timer and SPI clock, pin 7 SPI input
// - Port A pin 6 nine-way function map
// - Port B pins 0,1 timers, serial, comparator
// - Port B pins 2,3 flow, disable, remote lines
// - Port B pin 4 flow and driver enable
// - Port B pin 5 timers, serial, remote output
// - Port B pins 6,7 serial receive and transmit
// - Interrupt select routes port A pins
// - Interrupt select routes port B pins
// - Analog select; comparator input and reference
`timescale 1ns/100ps
module pin_function_mux
	import pin_mux_pkg::*;
#(
	parameter bit LEGACY_SEL = 1'b0
) (
	input wire logic i_core_clk, // System clock
	input wire logic i_rst, // Synchronous reset, active high
	input wire logic [ADDR_W-1:0] i_addr, // Register address
	input wire logic [7:0] i_wr_data, // Register write data
	input wire logic i_wr, // Write strobe
	input wire logic i_rd, // Read strobe
	output logic [7:0] o_rd_data, // Read data, cycle after strobe
	input wire logic [NFUNC-1:0] i_func_out, // Peripheral output levels
	input wire logic [NFUNC-1:0] i_func_oe, // Peripheral drive requests
	output logic [NFUNC-1:0] o_func_in, // Pin levels routed to peripherals
	input wire logic [NPIN-1:0] i_pin_in, // Package pin levels
	output logic [NPIN-1:0] o_pin_out, // Package pin drive levels
	output logic [NPIN-1:0] o_pin_oe, // Package pin output enables
	output logic [15:0] o_irq, // External interrupt lines
	output logic [NPIN-1:0] o_analog_en, // Pin given to analog use
	output logic o_cmp_in_en, // Comparator analog input connected
	output logic o_cmp_ref_en // Comparator reference connected
);

	// ==========================================================
	// State
	typedef struct packed {
		logic [NPIN-1:0][7:0] ctl;
		logic [NPIN-1:0] sync1;
		logic [NPIN-1:0] sync2;
		logic [7:0] rd_data;
		logic [NPIN-1:0] pin_out;
		logic [NPIN-1:0] pin_oe;
		logic [15:0] irq;
		logic [NFUNC-1:0] func_in;
	} state_t;

	state_t s_r;
	state_t s_nxt;

	localparam logic [5:0] SEL_MASK = LEGACY_SEL ? SEL_MASK_LEGACY : SEL_MASK_FULL;

	// ==========================================================
	// Select code to peripheral signal, per pin; anything unlisted is reserved
	function automatic func_t pin_func(input logic [4:0] pin, input logic [5:0] code);
		func_t f;
		f = f_none; // Zero and reserved codes attach nothing
		case ({pin, code})
			{5'h00, 6'h01}: f = f_t3b;
			{5'h00, 6'h0A}: f = f_sck10;
			{5'h00, 6'h0B}: f = f_rts10;
			{5'h00, 6'h2C}: f = f_sck010;
			{5'h00, 6'h2D}: f = f_rts010;
			{5'h00, 6'h2E}: f = f_drv_en010;
			{5'h01, 6'h01}: f = f_t3d;
			{5'h01, 6'h0A}: f = f_rxd10;
			{5'h01, 6'h2C}: f = f_rxd010;
			{5'h02, 6'h01}: f = f_t4a;
			{5'h02, 6'h0A}: f = f_txd10;
			{5'h02, 6'h2C}: f = f_txd010;
			{5'h03, 6'h01}: f = f_t4c;
			{5'h03, 6'h0A}: f = f_sck10;
			{5'h03, 6'h0B}: f = f_cts10;
			{5'h03, 6'h2C}: f = f_sck010;
			{5'h03, 6'h2D}: f = f_cts010;
			{5'h04, 6'h08}: f = f_t4d;
			{5'h04, 6'h0A}: f = f_rxd10;
			{5'h04, 6'h2C}: f = f_rxd010;
			{5'h05, 6'h08}: f = f_t4c;
			{5'h05, 6'h0A}: f = f_txd10;
			{5'h05, 6'h2C}: f = f_txd010;
			{5'h06, 6'h08}: f = f_odis4;
			{5'h06, 6'h0A}: f = f_rxd7;
			{5'h07, 6'h08}: f = f_odis0;
			{5'h07, 6'h0B}: f = f_cts7;
			{5'h08, 6'h01}: f = f_t4a;
			{5'h08, 6'h07}: f = f_clk_acc_ref;
			{5'h08, 6'h08}: f = f_t6d;
			{5'h08, 6'h0D}: f = f_spi_ss1;
			{5'h09, 6'h01}: f = f_t0b;
			{5'h09, 6'h02}: f = f_tclkc;
			{5'h09, 6'h08}: f = f_t7b;
			{5'h09, 6'h09}: f = f_adc_trig;
			{5'h09, 6'h0A}: f = f_sck5;
			{5'h09, 6'h0C}: f = f_sck12;
			{5'h09, 6'h0D}: f = f_spi_ss2;
			{5'h09, 6'h27}: f = f_t3b;
			{5'h0A, 6'h08}: f = f_t7a;
			{5'h0A, 6'h0A}: f = f_rxd5;
			{5'h0A, 6'h0C}: f = f_rxd12;
			{5'h0A, 6'h0D}: f = f_spi_ss3;
			{5'h0B, 6'h01}: f = f_t0d;
			{5'h0B, 6'h02}: f = f_tclkd;
			{5'h0B, 6'h08}: f = f_t5v;
			{5'h0B, 6'h0A}: f = f_rxd5;
			{5'h0B, 6'h27}: f = f_t4d;
			{5'h0C, 6'h01}: f = f_t5u;
			{5'h0C, 6'h02}: f = f_tclka;
			{5'h0C, 6'h05}: f = f_t8rst0;
			{5'h0C, 6'h08}: f = f_t4c;
			{5'h0C, 6'h09}: f = f_adc_stat;
			{5'h0C, 6'h0A}: f = f_txd5;
			{5'h0C, 6'h0C}: f = f_txd12;
			{5'h0C, 6'h0D}: f = f_spi_ss0;
			{5'h0C, 6'h27}: f = f_t7c;
			{5'h0D, 6'h08}: f = f_t6b;
			{5'h0D, 6'h0D}: f = f_spi_clk;
			{5'h0E, 6'h01}: f = f_t5v;
			{5'h0E, 6'h02}: f = f_tclkb;
			{5'h0E, 6'h05}: f = f_t8clk3;
			{5'h0E, 6'h07}: f = f_odis1;
			{5'h0E, 6'h08}: f = f_t3d;
			{5'h0E, 6'h0B}: f = f_cts5;
			{5'h0E, 6'h0C}: f = f_cts12;
			{5'h0E, 6'h0D}: f = f_spi_mo;
			{5'h0E, 6'h27}: f = f_t6b;
			{5'h0F, 6'h0D}: f = f_spi_mi;
			{5'h10, 6'h01}: f = f_t5w;
			{5'h10, 6'h02}: f = f_t3d;
			{5'h10, 6'h0A}: f = f_rxd4;
			{5'h10, 6'h0B}: f = f_rxd6;
			{5'h10, 6'h0D}: f = f_spi_clk;
			{5'h11, 6'h01}: f = f_t0c;
			{5'h11, 6'h02}: f = f_t4c;
			{5'h11, 6'h05}: f = f_t8clk0;
			{5'h11, 6'h0A}: f = f_txd4;
			{5'h11, 6'h0B}: f = f_txd6;
			{5'h11, 6'h1E}: f = f_cmp_out1;
			{5'h12, 6'h0A}: f = f_cts4;
			{5'h12, 6'h0B}: f = f_cts6;
			{5'h13, 6'h01}: f = f_t0a;
			{5'h13, 6'h02}: f = f_t4a;
			{5'h13, 6'h05}: f = f_t8out0;
			{5'h13, 6'h07}: f = f_odis11;
			{5'h13, 6'h0A}: f = f_sck4;
			{5'h13, 6'h0B}: f = f_sck6;
			{5'h13, 6'h1D}: f = f_rtim_in2;
			{5'h13, 6'h26}: f = f_rc_rx;
			{5'h14, 6'h0B}: f = f_cts9;
			{5'h14, 6'h24}: f = f_cts11;
			{5'h14, 6'h2C}: f = f_cts011;
			{5'h14, 6'h2E}: f = f_drv_en011;
			{5'h15, 6'h01}: f = f_t2a;
			{5'h15, 6'h02}: f = f_t1b;
			{5'h15, 6'h05}: f = f_t8rst1;
			{5'h15, 6'h07}: f = f_odis4;
			{5'h15, 6'h0A}: f = f_sck9;
			{5'h15, 6'h1D}: f = f_rtim_out2;
			{5'h15, 6'h24}: f = f_sck11;
			{5'h15, 6'h2C}: f = f_sck011;
			{5'h16, 6'h01}: f = f_t3d;
			{5'h16, 6'h0A}: f = f_rxd9;
			{5'h16, 6'h24}: f = f_rxd11;
			{5'h16, 6'h2C}: f = f_rxd011;
			{5'h17, 6'h01}: f = f_t3b;
			{5'h17, 6'h0A}: f = f_txd9;
			{5'h17, 6'h24}: f = f_txd11;
			{5'h17, 6'h2C}: f = f_txd011;
			default: f = f_none;
		endcase
		return f;
	endfunction

	// ==========================================================
	// Next-state logic
	always_comb begin
		func_t fsel [NPIN];
		for (int p = 0; p < NPIN; p++) begin
			fsel[p] = f_none;
		end
		s_nxt = s_r;

		// Register write; select field narrowed in the legacy variant
		if (i_wr && (i_addr <= REG_LAST)) begin
			s_nxt.ctl[i_addr] = {i_wr_data[7:6], i_wr_data[5:0] & SEL_MASK};
		end

		// Read data stand only in the cycle after the strobe; unmapped reads zero
		s_nxt.rd_data = 8'h00;
		if (i_rd && (i_addr <= REG_LAST)) begin
			s_nxt.rd_data = s_r.ctl[i_addr];
		end

		// Two-stage synchroniser on the package pins
		s_nxt.sync1 = i_pin_in;
		s_nxt.sync2 = s_r.sync1;

		// Function routing; an analog pin carries its interrupt line but no peripheral function
		s_nxt.func_in = '0;
		s_nxt.irq = '0;
		for (int p = 0; p < NPIN; p++) begin
			if (!s_r.ctl[p][ANALOG_SEL_BIT]) begin
				fsel[p] = pin_func(5'(p), s_r.ctl[p][SEL_LSB +: SEL_W]);
			end
			s_nxt.pin_oe[p] = (fsel[p] != f_none) && i_func_oe[fsel[p]];
			s_nxt.pin_out[p] = (fsel[p] != f_none) && i_func_out[fsel[p]];
			if (fsel[p] != f_none) begin
				s_nxt.func_in[fsel[p]] = s_nxt.func_in[fsel[p]] | s_r.sync2[p]; // Shared input ORed
			end
			// Interrupt select routes the pin to its external interrupt line
			if (IRQ_VALID[p] && s_r.ctl[p][IRQ_SEL_BIT] && s_r.sync2[p]) begin
				s_nxt.irq[IRQ_LINE[p]] = 1'b1;
			end
		end
	end

	// ==========================================================
	// State register, cleared by reset
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ==========================================================
	// Outputs
	assign o_rd_data = s_r.rd_data;
	assign o_func_in = s_r.func_in;
	assign o_pin_out = s_r.pin_out;
	assign o_pin_oe = s_r.pin_oe;
	assign o_irq = s_r.irq;
	for (genvar g = 0; g < NPIN; g++) begin : g_analog
		assign o_analog_en[g] = s_r.ctl[g][ANALOG_SEL_BIT];
	end
	assign o_cmp_in_en = s_r.ctl[PIN_CMP_IN][ANALOG_SEL_BIT];
	assign o_cmp_ref_en = s_r.ctl[PIN_CMP_REF][ANALOG_SEL_BIT];

	// ==========================================================
	// Assertions
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	AST_WRITE_STORES: assert property (
		(i_wr && i_addr <= REG_LAST) |=> s_r.ctl[$past(i_addr)] ==
			{$past(i_wr_data[7:6]), $past(i_wr_data[5:0]) & SEL_MASK})
		else $error("written value not held in control register");
	AST_READ_BACK: assert property (
		(i_rd && i_addr <= REG_LAST && !i_wr) |=> o_rd_data == $past(s_r.ctl[i_addr]))
		else $error("read data differ from control register");
	AST_READ_IDLE: assert property (
		!i_rd |=> o_rd_data == 8'h00)
		else $error("read data present without a read strobe");
	AST_RESET_CLEAR: assert property (@(posedge i_core_clk) disable iff (1'b0)
		i_rst |=> s_r.ctl == '0 && o_pin_oe == '0)
		else $error("reset left a register or drive set");
	AST_LEGACY_WIDTH: assert property (
		LEGACY_SEL |-> s_r.ctl[0][5:4] == 2'b00 && s_r.ctl[23][5:4] == 2'b00)
		else $error("legacy select field above four bits");
	AST_HIZ_CODE: assert property (
		s_r.ctl[9][5:0] == SEL_HIZ |=> !o_pin_oe[9] && !o_pin_out[9])
		else $error("zero select code drives the pin");
	AST_P80_SCK: assert property (
		(s_r.ctl[0] == 8'h0A) |=>
			o_pin_oe[0] == $past(i_func_oe[f_sck10]) && o_pin_out[0] == $past(i_func_out[f_sck10]))
		else $error("port 8 pin 0 clock not routed");
	AST_PA0_SS: assert property (
		(s_r.ctl[8] == 8'h0D) |=> o_pin_oe[8] == $past(i_func_oe[f_spi_ss1]))
		else $error("port A pin 0 slave select not routed");
	AST_PB1_CMP: assert property (
		(s_r.ctl[17] == 8'h1E) |=> o_pin_out[17] == $past(i_func_out[f_cmp_out1]))
		else $error("port B pin 1 comparator output not routed");
	AST_RESERVED: assert property (
		(s_r.ctl[6][5:0] == 6'h01 && !s_r.ctl[6][7]) |=> !o_pin_oe[6])
		else $error("reserved code drives the pin");
	AST_RX_PATH: assert property (
		(s_r.ctl[1] == 8'h0A && s_r.ctl[4][5:0] != 6'h0A && i_pin_in[1]) [*3] |=> o_func_in[f_rxd10])
		else $error("pin level not delivered to receive line");
	AST_IRQ_PA1: assert property (
		(s_r.ctl[9][IRQ_SEL_BIT] && s_r.sync2[9]) |=> o_irq[11])
		else $error("port A pin 1 interrupt line not raised");
	AST_IRQ_PB7: assert property (
		!(s_r.ctl[23][IRQ_SEL_BIT] && s_r.sync2[23]) |=> !o_irq[15])
		else $error("interrupt line 15 raised without its pin");
	AST_ANALOG: assert property (
		s_r.ctl[PIN_CMP_IN][ANALOG_SEL_BIT] |-> o_cmp_in_en ##1 !o_pin_oe[PIN_CMP_IN])
		else $error("analog pin still driven digitally");

	// One listed code of each remaining pin map except port 8 pin 2 and port B pin 2 routes its function to the pad
	AST_P81_RXD: assert property (
		(s_r.ctl[1] == 8'h2C) |=> o_pin_out[1] == $past(i_func_out[f_rxd010]))
		else $error("port 8 pin 1 channel 010 receive not routed");
	AST_P83_CTS: assert property (
		(s_r.ctl[3] == 8'h0B) |=> o_pin_oe[3] == $past(i_func_oe[f_cts10]))
		else $error("port 8 pin 3 flow line not routed");
	AST_P86_TIMER: assert property (
		(s_r.ctl[4] == 8'h08) |=> o_pin_out[4] == $past(i_func_out[f_t4d]))
		else $error("port 8 pin 6 timer line not routed");
	AST_P87_TXD: assert property (
		(s_r.ctl[5] == 8'h2C) |=> o_pin_oe[5] == $past(i_func_oe[f_txd010]))
		else $error("port 8 pin 7 channel 010 transmit not routed");
	AST_P92_ODIS: assert property (
		(s_r.ctl[6] == 8'h08) |=> o_pin_oe[6] == $past(i_func_oe[f_odis4]))
		else $error("port 9 pin 2 output-disable input not routed");
	AST_P93_FLOW: assert property (
		(s_r.ctl[7] == 8'h0B) |=> o_pin_out[7] == $past(i_func_out[f_cts7]))
		else $error("port 9 pin 3 flow line not routed");
	AST_PA1_TRIG: assert property (
		(s_r.ctl[9] == 8'h09) |=> o_pin_oe[9] == $past(i_func_oe[f_adc_trig]))
		else $error("port A pin 1 converter trigger not routed");
	AST_PA1_TIMER: assert property (
		(s_r.ctl[9] == 8'h27) |=> o_pin_out[9] == $past(i_func_out[f_t3b]))
		else $error("port A pin 1 timer line not routed");
	AST_PA2_SS: assert property (
		(s_r.ctl[10] == 8'h0D) |=> o_pin_oe[10] == $past(i_func_oe[f_spi_ss3]))
		else $error("port A pin 2 slave select not routed");
	AST_PA3_CLK: assert property (
		(s_r.ctl[11] == 8'h02) |=> o_pin_out[11] == $past(i_func_out[f_tclkd]))
		else $error("port A pin 3 timer clock not routed");
	AST_PA4_STAT: assert property (
		(s_r.ctl[12] == 8'h09) |=> o_pin_oe[12] == $past(i_func_oe[f_adc_stat]))
		else $error("port A pin 4 converter status not routed");
	AST_PA4_TIMER: assert property (
		(s_r.ctl[12] == 8'h27) |=> o_pin_out[12] == $past(i_func_out[f_t7c]))
		else $error("port A pin 4 timer line not routed");
	AST_PA5_CLK: assert property (
		(s_r.ctl[13] == 8'h0D) |=> o_pin_oe[13] == $past(i_func_oe[f_spi_clk]))
		else $error("port A pin 5 serial peripheral clock not routed");
	AST_PA7_SPI_IN: assert property (
		(s_r.ctl[15] == 8'h0D) |=> o_pin_out[15] == $past(i_func_out[f_spi_mi]))
		else $error("port A pin 7 serial peripheral input not routed");
	AST_PA6_FLOW: assert property (
		(s_r.ctl[14] == 8'h0C) |=> o_pin_oe[14] == $past(i_func_oe[f_cts12]))
		else $error("port A pin 6 channel 12 flow line not routed");
	AST_PB0_TIMER: assert property (
		(s_r.ctl[16] == 8'h02) |=> o_pin_out[16] == $past(i_func_out[f_t3d]))
		else $error("port B pin 0 timer line not routed");
	AST_PB3_REMOTE: assert property (
		(s_r.ctl[19] == 8'h26) |=> o_pin_oe[19] == $past(i_func_oe[f_rc_rx]))
		else $error("port B pin 3 remote-control input not routed");
	AST_PB4_DRV_EN: assert property (
		(s_r.ctl[20] == 8'h2E) |=> o_pin_out[20] == $past(i_func_out[f_drv_en011]))
		else $error("port B pin 4 driver enable not routed");
	AST_PB5_TIMER_OUT: assert property (
		(s_r.ctl[21] == 8'h1D) |=> o_pin_oe[21] == $past(i_func_oe[f_rtim_out2]))
		else $error("port B pin 5 remote timer output not routed");
	AST_PB6_RXD: assert property (
		(s_r.ctl[22] == 8'h2C) |=> o_pin_out[22] == $past(i_func_out[f_rxd011]))
		else $error("port B pin 6 channel 011 receive not routed");
	AST_PB7_TXD: assert property (
		(s_r.ctl[23] == 8'h24) |=> o_pin_oe[23] == $past(i_func_oe[f_txd11]))
		else $error("port B pin 7 channel 11 transmit not routed");

	COV_WRITE_READ: cover property (i_wr ##1 i_rd && i_addr == $past(i_addr));
	COV_PIN_DRIVEN: cover property (o_pin_oe[0] && o_pin_out[0]);
	COV_IRQ: cover property (o_irq[15]);
	COV_ANALOG: cover property (o_cmp_in_en && o_cmp_ref_en);
	COV_RX_PATH: cover property (o_func_in[f_rxd10] && s_r.ctl[1] == 8'h0A);

endmodule

// ==== verification/pin_pad_model.sv ====
// Package pad model standing between the multiplexer and the board
`timescale 1ns/100ps
module pin_pad_model (
	input wire logic [23:0] i_drv, // Drive level from the multiplexer
	input wire logic [23:0] i_drv_en, // Drive enable from the multiplexer
	input wire logic [23:0] i_board, // Level the board applies to an undriven pad
	output logic [23:0] o_level // Resolved pad level seen by the input buffer
);
	// A driven pad follows the device, a released pad follows the board, never a stale value
	assign o_level = (i_drv_en & i_drv) | (~i_drv_en & i_board);
endmodule

// ==== verification/pin_function_mux_bench.sv ====
// Self-checking testbench of the pin function multiplexer
`timescale 1ns/100ps
module pin_function_mux_bench;
	import pin_mux_pkg::*;
	// ==========================================================
	// Stimulus tables: {pin index, select code, attached function}
	localparam int NT = 55;
	localparam logic [17:0] TBL [NT] = '{
		{5'h00, 6'h01, f_t3b}, {5'h00, 6'h0B, f_rts10}, {5'h00, 6'h2C, f_sck010},
		{5'h00, 6'h2E, f_drv_en010}, {5'h01, 6'h01, f_t3d}, {5'h01, 6'h2C, f_rxd010},
		{5'h02, 6'h0A, f_txd10}, {5'h03, 6'h0B, f_cts10}, {5'h03, 6'h2D, f_cts010},
		{5'h04, 6'h08, f_t4d}, {5'h05, 6'h08, f_t4c}, {5'h05, 6'h2C, f_txd010},
		{5'h06, 6'h08, f_odis4}, {5'h06, 6'h0A, f_rxd7}, {5'h07, 6'h0B, f_cts7},
		{5'h08, 6'h07, f_clk_acc_ref}, {5'h08, 6'h08, f_t6d}, {5'h08, 6'h0D, f_spi_ss1},
		{5'h09, 6'h09, f_adc_trig}, {5'h09, 6'h0C, f_sck12}, {5'h09, 6'h27, f_t3b},
		{5'h0A, 6'h08, f_t7a}, {5'h0A, 6'h0C, f_rxd12}, {5'h0A, 6'h0D, f_spi_ss3},
		{5'h0B, 6'h02, f_tclkd}, {5'h0B, 6'h08, f_t5v}, {5'h0B, 6'h27, f_t4d},
		{5'h0C, 6'h05, f_t8rst0}, {5'h0C, 6'h09, f_adc_stat}, {5'h0C, 6'h27, f_t7c},
		{5'h0D, 6'h08, f_t6b}, {5'h0D, 6'h0D, f_spi_clk}, {5'h0F, 6'h0D, f_spi_mi},
		{5'h0E, 6'h07, f_odis1}, {5'h0E, 6'h0C, f_cts12}, {5'h0E, 6'h27, f_t6b},
		{5'h10, 6'h02, f_t3d}, {5'h11, 6'h0B, f_txd6}, {5'h11, 6'h1E, f_cmp_out1},
		{5'h12, 6'h0A, f_cts4}, {5'h13, 6'h07, f_odis11}, {5'h13, 6'h1D, f_rtim_in2},
		{5'h13, 6'h26, f_rc_rx}, {5'h14, 6'h24, f_cts11}, {5'h14, 6'h2C, f_cts011},
		{5'h14, 6'h2E, f_drv_en011}, {5'h15, 6'h07, f_odis4}, {5'h15, 6'h1D, f_rtim_out2},
		{5'h15, 6'h24, f_sck11}, {5'h16, 6'h0A, f_rxd9}, {5'h17, 6'h24, f_txd11},
		{5'h16, 6'h2C, f_rxd011}, {5'h17, 6'h01, f_t3b},
		{5'h00, 6'h0A, f_sck10}, {5'h01, 6'h0A, f_rxd10}};
	// Interrupt line fed by port A pins 0..7 then port B pins 0..7
	localparam logic [3:0] LINE [16] = '{4'h0, 4'hB, 4'hA, 4'h6, 4'h5, 4'h5, 4'hE, 4'h7,
		4'hC, 4'h4, 4'h2, 4'h3, 4'h4, 4'hD, 4'h6, 4'hF};
	logic i_core_clk, i_rst, i_wr, i_rd, rd_d;
	logic [4:0] i_addr;
	logic [7:0] i_wr_data, o_rd_data, leg_rd_data;
	logic [NFUNC-1:0] i_func_out, i_func_oe, o_func_in, exp_fin;
	logic [23:0] i_pin_in, o_pin_out, o_pin_oe, o_analog_en, board;
	logic [15:0] o_irq;
	logic o_cmp_in_en, o_cmp_ref_en;
	logic [7:0] rdq[$], legq[$];
	logic [95:0] rnd;
	int n_mismatch = 0, checked = 0, p, f;

	// ==========================================================
	// Design instances and pads
	pin_function_mux #(.LEGACY_SEL(1'b0)) DUT (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data),
		.i_func_out(i_func_out), .i_func_oe(i_func_oe), .o_func_in(o_func_in),
		.i_pin_in(i_pin_in), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_irq(o_irq),
		.o_analog_en(o_analog_en), .o_cmp_in_en(o_cmp_in_en), .o_cmp_ref_en(o_cmp_ref_en));
	// Four-bit select variant, watched on its read port only
	pin_function_mux #(.LEGACY_SEL(1'b1)) DUT_LEGACY (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd),
		.o_rd_data(leg_rd_data), .i_func_out(i_func_out), .i_func_oe(i_func_oe), .o_func_in(),
		.i_pin_in(i_pin_in), .o_pin_out(), .o_pin_oe(), .o_irq(), .o_analog_en(),
		.o_cmp_in_en(), .o_cmp_ref_en());
	pin_pad_model PADS (.i_drv(o_pin_out), .i_drv_en(o_pin_oe), .i_board(board),
		.o_level(i_pin_in));

	// 100 MHz clock
	initial begin
		i_core_clk = 1'b0;
		forever #5 i_core_clk = ~i_core_clk;
	end

	// ==========================================================
	// Shared tasks
	task automatic check(input logic [127:0] seen, input logic [127:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up();
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		i_addr <= a;
		i_wr_data <= d;
		i_wr <= 1'b1;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask

	// Read strobe; expected data of both variants noted for the watcher
	task automatic rd(input logic [4:0] a, input logic [7:0] e, input logic [7:0] el);
		@(posedge i_core_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		rdq.push_back(e);
		legq.push_back(el);
		@(posedge i_core_clk);
		i_rd <= 1'b0;
	endtask

	// Read data watcher: the answer stands only in the cycle after the strobe
	always @(posedge i_core_clk) begin
		if (rd_d) begin
			check(o_rd_data, rdq.pop_front());
			check(leg_rd_data, legq.pop_front());
		end
		rd_d <= i_rd;
	end

	// Hang guard
	initial begin
		#100000;
		n_mismatch++;
		wrap_up();
	end

	// ==========================================================
	// Main sequence
	initial begin
		i_rst = 1'b1;
		i_wr = 1'b0;
		i_rd = 1'b0;
		rd_d = 1'b0;
		i_addr = 5'h00;
		i_wr_data = 8'h00;
		i_func_out = '0;
		i_func_oe = '0;
		board = 24'h000000;
		void'($urandom(39523));
		repeat (6) @(posedge i_core_clk);
		i_rst <= 1'b0;
		// Reset values, unmapped reads, random write then read back
		for (int a = 0; a < 32; a++) rd(a[4:0], 8'h00, 8'h00);
		for (int a = 0; a < 32; a++) begin
			rnd = {$urandom, $urandom, $urandom};
			wr(a[4:0], rnd[7:0]);
			rd(a[4:0], (a < NPIN) ? rnd[7:0] : 8'h00, (a < NPIN) ? (rnd[7:0] & 8'hCF) : 8'h00);
		end
		// Mid-run reset clears every register
		@(posedge i_core_clk);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_core_clk);
		i_rst <= 1'b0;
		for (int a = 0; a < 32; a++) rd(a[4:0], 8'h00, 8'h00);
		// Every tabled code, then a reserved code, analog use and code zero on that pin
		for (int k = 0; k < NT; k++) begin
			p = TBL[k][17:13];
			f = TBL[k][6:0];
			rnd = {$urandom, $urandom, $urandom};
			@(posedge i_core_clk);
			i_func_out <= rnd[NFUNC-1:0];
			i_func_oe <= rnd[95:96-NFUNC] | (NFUNC'(1) << f);
			board <= rnd[23:0] ^ rnd[47:24];
			exp_fin = '0;
			exp_fin[f] = rnd[f];
			wr(p[4:0], {2'b00, TBL[k][12:7]});
			@(posedge i_core_clk);
			#1;
			check(o_pin_oe, 24'h000001 << p);
			check(o_pin_out, 24'(rnd[f]) << p);
			repeat (3) @(posedge i_core_clk);
			#1;
			check(o_func_in, exp_fin);
			wr(p[4:0], 8'h3F);
			@(posedge i_core_clk);
			#1;
			check(o_pin_oe, 24'h000000);
			wr(p[4:0], {2'b10, TBL[k][12:7]});
			@(posedge i_core_clk);
			#1;
			check(o_pin_oe, 24'h000000);
			check(o_analog_en, 24'h000001 << p);
			check({o_cmp_in_en, o_cmp_ref_en}, {p == 11, p == 12});
			wr(p[4:0], 8'h00);
			repeat (4) @(posedge i_core_clk);
			#1;
			check(o_pin_oe, 24'h000000);
			check(o_func_in, '0);
		end
		// Interrupt lines follow the pad level while interrupt select is set
		for (int k = 0; k < 16; k++) begin
			wr(5'(k + 8), 8'h40);
			board <= 24'hFFFFFF;
			repeat (3) @(posedge i_core_clk);
			#1;
			check(o_irq, 16'h0001 << LINE[k]);
			@(posedge i_core_clk);
			board <= 24'h000000;
			repeat (3) @(posedge i_core_clk);
			#1;
			check(o_irq, 16'h0000);
			wr(5'(k + 8), 8'h00);
		end
		repeat (3) @(posedge i_core_clk);
		wrap_up();
	end
endmodule
